/* ppg_pkg.sv */
// Shared constants and types for the pulse generator timer
package ppg_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_WIDTH  = 8'h08;
  localparam logic [7:0] A_COUNT  = 8'h0C;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_MASK   = 8'h14;
  localparam logic [7:0] A_STATE  = 8'h18;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int F_START   = 0;
  localparam int F_ONESHOT = 2;
  localparam int F_FFCTL   = 3;
  localparam int F_MODE    = 4;
  localparam int F_CLKSEL  = 6;
  localparam int CNT_W     = 16;
  localparam int DIV_W     = 8;
  localparam int STAT_W    = 2;
  localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
  // ----------------------------------------
  // Trigger noise filter timing
  // ----------------------------------------
  localparam int CLK_NS      = 10;
  localparam int TRIG_REJ_NS = 40;
  localparam int TRIG_ACC_NS = 120;
  // Midway between reject and accept, whole cycles
  localparam int FILT_CYC = (TRIG_REJ_NS + TRIG_ACC_NS) / (2 * CLK_NS);
  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_CMD  = 2'b01,
    ST_RISE = 2'b10,
    ST_FALL = 2'b11
  } start_t;
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_PPG   = 2'b01,
    MODE_RSV2  = 2'b10,
    MODE_RSV3  = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_ARMED = 2'b01,
    S_RUN   = 2'b10
  } run_state_t;
endpackage : ppg_pkg

/* timer_link_if.sv */
// Internal link between the timer core, trigger filter and prescaler
`timescale 1ns/1ps
interface timer_link_if;
  logic       trig_rise;
  logic       trig_fall;
  logic       tick;
  logic       div_clr;
  logic [2:0] clk_sel;
  modport filt  (output trig_rise, output trig_fall);
  modport presc (input div_clr, input clk_sel, output tick);
  modport core  (input trig_rise, input trig_fall, input tick,
                 output div_clr, output clk_sel);
endinterface : timer_link_if

/* trig_filter.sv */
// Synchroniser and noise filter for the external trigger input
`timescale 1ns/1ps
module trig_filter
  import ppg_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   trig_in,
  timer_link_if.filt  lnk
);
  logic       s1_r;
  logic       s2_r;
  logic       s3_r;
  logic       lvl_r;
  logic [3:0] cnt_r;
  logic       rise_r;
  logic       fall_r;

  // ----------------------------------------
  // Three-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= trig_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ----------------------------------------
  // Stability filter, short glitches dropped
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_r  <= 1'b0;
      cnt_r  <= 4'h0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      if (s2_r == s3_r && s3_r != lvl_r) begin
        if (cnt_r == 4'(FILT_CYC - 1)) begin
          lvl_r  <= s3_r;
          cnt_r  <= 4'h0;
          rise_r <= s3_r;
          fall_r <= ~s3_r;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end

  assign lnk.trig_rise = rise_r;
  assign lnk.trig_fall = fall_r;

  a_filter_stable: assert property (@(posedge pclk) disable iff (!presetn)
    rise_r |-> $past(s3_r, 1) && $past(s3_r, 4) && $past(s3_r, 7))
    else $error("trigger rise accepted on short pulse");
endmodule : trig_filter

/* src_prescaler.sv */
// Source clock tick generator for the up-counter
`timescale 1ns/1ps
module src_prescaler
  import ppg_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  timer_link_if.presc lnk
);
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] msk;

  // Divide by two to the power of the select value
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    div_mask = DIV_W'((9'h001 << sel) - 9'h001);
  endfunction : div_mask

  assign msk = div_mask(lnk.clk_sel);
  assign lnk.tick = ((div_r & msk) == msk) && !lnk.div_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (lnk.div_clr) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DIV_W'(1);
    end
  end
endmodule : src_prescaler

/* ppg_timer.sv */
// Programmable pulse output timer with APB register access
// Notes on behaviour
// - Counts source clock; command or trigger start
// - One-shot bit selects single or repeated periods
// - Width match inverts output, interrupts, keeps counting; on a same-tick period match the output is not inverted and the count clears
// - Period match inverts, interrupts, clears, continues; on a same-tick width match the output is not inverted
// - Software stop holds current output level
// - One-shot period match clears start, halts, holds
// - Output pin is inverse of timer flip-flop
// - Reset clears timer flip-flop to zero
// - Inverted stop makes flip-flop load inverse
// - Trigger filter rejects short pulses
// - Start field selects rising or falling trigger
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module ppg_timer
  import ppg_pkg::*;
#(
  parameter int CW = CNT_W
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_trigger_input,
  output logic             pulse_output_pin,
  output logic             timer_interrupt_request,
  output logic             irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  timer_link_if lnk ();

  start_t      start_r;
  mode_t       mode_r;
  logic        one_shot_r;
  logic        ff_ctl_r;
  logic [2:0]  clk_sel_r;
  logic [CW-1:0] period_r;
  logic [CW-1:0] width_r;
  logic [CW-1:0] cnt_r;
  run_state_t  state_r;
  logic        pin_r;
  logic        start_ff_r;
  logic        req_r;
  logic [STAT_W-1:0] sts_r;
  logic [STAT_W-1:0] sts_nxt;
  logic [STAT_W-1:0] mask_r;
  logic        irq_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        setup;
  logic        wr;
  logic        ctrl_wr;
  logic        tick_run;
  logic        w_hit;
  logic        p_hit;
  logic        os_end;
  logic        trig_hit;
  logic        ff_new;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == A_CTRL) || (a == A_PERIOD) || (a == A_WIDTH) ||
              (a == A_COUNT) || (a == A_STAT) || (a == A_MASK) ||
              (a == A_STATE);
  endfunction : addr_ok

  trig_filter u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .trig_in (external_trigger_input),
    .lnk     (lnk.filt)
  );

  src_prescaler u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk.presc)
  );

  // Divider held cleared outside a run so each period starts aligned
  assign lnk.div_clr = (state_r != S_RUN);
  assign lnk.clk_sel = clk_sel_r;

  assign setup    = psel && !penable;
  assign wr       = psel && penable && pwrite && pready_r && !pslverr_r;
  assign ctrl_wr  = wr && (paddr == A_CTRL);
  assign tick_run = (state_r == S_RUN) && lnk.tick &&
                    (start_r != ST_STOP) && (mode_r == MODE_PPG);
  assign w_hit    = tick_run && (cnt_r == width_r);
  assign p_hit    = tick_run && (cnt_r == period_r);
  assign os_end   = p_hit && one_shot_r;
  assign trig_hit = (start_r == ST_RISE) ? lnk.trig_rise : lnk.trig_fall;
  assign ff_new   = pwdata[F_FFCTL];

  // ----------------------------------------
  // APB slave, one wait-free answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !addr_ok(paddr);
      prdata_r  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          A_CTRL:   prdata_r <= {23'h0, clk_sel_r, mode_r, ff_ctl_r,
                                 one_shot_r, start_r};
          A_PERIOD: prdata_r <= {16'h0, period_r};
          A_WIDTH:  prdata_r <= {16'h0, width_r};
          A_COUNT:  prdata_r <= {16'h0, cnt_r};
          A_STAT:   prdata_r <= {30'h0, sts_r};
          A_MASK:   prdata_r <= {30'h0, mask_r};
          A_STATE:  prdata_r <= {28'h0, ~pin_r, pin_r, state_r};
          default:  prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control and compare registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r    <= ST_STOP;
      mode_r     <= MODE_TIMER;
      one_shot_r <= 1'b0;
      ff_ctl_r   <= 1'b0;
      clk_sel_r  <= 3'h0;
      period_r   <= '0;
      width_r    <= '0;
      mask_r     <= MASK_RST;
    end else begin
      if (ctrl_wr) begin
        start_r    <= start_t'(pwdata[F_START +: 2]);
        mode_r     <= mode_t'(pwdata[F_MODE +: 2]);
        one_shot_r <= pwdata[F_ONESHOT];
        ff_ctl_r   <= ff_new;
        clk_sel_r  <= pwdata[F_CLKSEL +: 3];
      end
      // Hardware stop beats a same-cycle software write
      if (os_end) begin
        start_r <= ST_STOP;
      end
      if (wr && paddr == A_PERIOD) begin
        period_r <= pwdata[CW-1:0];
      end
      if (wr && paddr == A_WIDTH) begin
        width_r <= pwdata[CW-1:0];
      end
      if (wr && paddr == A_MASK) begin
        mask_r <= pwdata[STAT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Run control and up-counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (mode_r == MODE_PPG && start_r == ST_CMD) begin
            state_r <= S_RUN;
            cnt_r   <= '0;
          end else if (mode_r == MODE_PPG && start_r != ST_STOP) begin
            state_r <= S_ARMED;
          end
        end
        S_ARMED: begin
          if (mode_r != MODE_PPG || start_r == ST_STOP) begin
            state_r <= S_IDLE;
          end else if (trig_hit) begin
            state_r <= S_RUN;
            cnt_r   <= '0;
          end
        end
        S_RUN: begin
          if (mode_r != MODE_PPG || start_r == ST_STOP) begin
            state_r <= S_IDLE;
          end else if (os_end) begin
            state_r <= S_IDLE;
          end else if (p_hit) begin
            cnt_r <= '0;
          end else if (tick_run) begin
            cnt_r <= cnt_r + CW'(1);
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Timer flip-flop, pin carries its inverse
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r      <= 1'b1;
      start_ff_r <= 1'b0;
    end else if (tick_run && (w_hit ^ p_hit)) begin
      pin_r <= ~pin_r;
    end else if (ctrl_wr && state_r != S_RUN) begin
      if (pwdata[F_MODE +: 2] != MODE_PPG) begin
        start_ff_r <= ~pin_r;
      end else if (start_ff_r != ~pin_r) begin
        pin_r      <= ff_new;
        start_ff_r <= ~ff_new;
      end else begin
        pin_r      <= ~ff_new;
        start_ff_r <= ff_new;
      end
    end
  end

  // ----------------------------------------
  // Interrupt request and status
  // ----------------------------------------
  always_comb begin
    sts_nxt = sts_r;
    if (wr && paddr == A_STAT) begin
      sts_nxt = sts_r & ~pwdata[STAT_W-1:0];
    end
    // A new event wins over a same-cycle clear
    sts_nxt = sts_nxt | {p_hit, w_hit};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
      sts_r <= STAT_RST;
      irq_r <= 1'b0;
    end else begin
      req_r <= w_hit || p_hit;
      sts_r <= sts_nxt;
      irq_r <= |(sts_nxt & mask_r);
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign pulse_output_pin        = pin_r;
  assign timer_interrupt_request = req_r;
  assign irq                     = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_width_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (w_hit && !p_hit) |=> (pin_r != $past(pin_r)) &&
                          (cnt_r == $past(cnt_r) + CW'(1)))
    else $error("width match did not invert and keep counting");

  a_period_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (p_hit && !w_hit && !one_shot_r) |=> (cnt_r == '0) && (state_r == S_RUN) &&
                                         (pin_r != $past(pin_r)))
    else $error("period match did not clear and invert");

  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == S_RUN && start_r == ST_STOP) |=> (state_r == S_IDLE) &&
                                                 (pin_r == $past(pin_r)))
    else $error("software stop changed output");

  a_oneshot_halt: assert property (@(posedge pclk) disable iff (!presetn)
    os_end |=> (start_r == ST_STOP) && (state_r == S_IDLE) ##1 $stable(pin_r))
    else $error("one-shot did not halt");

  a_cmd_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == S_IDLE && mode_r == MODE_PPG && start_r == ST_CMD)
      |=> (state_r == S_RUN) && (cnt_r == '0))
    else $error("command start missed");

  a_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == S_ARMED && mode_r == MODE_PPG && start_r == ST_RISE &&
     lnk.trig_rise) |=> (state_r == S_RUN))
    else $error("rising trigger did not start");

  a_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    $past(state_r == S_RUN) |-> (timer_interrupt_request ==
      ((pulse_output_pin != $past(pulse_output_pin)) || $past(w_hit && p_hit))))
    else $error("interrupt pulse not tied to compare");

  a_stopped_count: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == S_IDLE && $past(state_r) == S_IDLE) |-> $stable(cnt_r) && !req_r)
    else $error("counter moved while stopped");
endmodule : ppg_timer

/* pulse_load.sv */
// External load model that logs edge times of the pulse output pin
`timescale 1ns/1ps
module pulse_load
(
  input wire logic pclk,
  input wire logic pin
);
  // ----------------------------------------
  // Edge log
  // ----------------------------------------
  // Passive load: it only watches, so it can never mask a pin fault
  int   cyc;
  int   stamps[$];
  logic last;
  initial begin
    cyc  = 0;
    last = 1'b1;
  end
  always @(posedge pclk) begin
    cyc++;
    if (pin !== last) begin
      stamps.push_back(cyc);
    end
    last = pin;
  end
endmodule : pulse_load

/* programmable_pulse_output_tb_top.sv */
// Self-checking bench for the pulse output timer
`timescale 1ns/1ps
module programmable_pulse_output_tb_top;
  import ppg_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig;
  logic        pin;
  logic        req;
  logic        irq;
  logic [31:0] r;
  logic        e;
  int          n_errors;
  int          n_checks;
  int          n_req;
  int          w;
  int          p;
  int          q0;
  int          sl;
  ppg_timer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_trigger_input(trig),
    .pulse_output_pin(pin), .timer_interrupt_request(req), .irq(irq));
  pulse_load u_load (.pclk(pclk), .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (req === 1'b1) n_req++;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic chk_n(input int got, input int exp, input string m);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask : chk_n
  // Zero wait states expected, but the master never counts on it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("CHECK FAILED t=%0t apb timeout", $time);
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] cw(input logic [1:0] s, input logic o, input logic f,
                                     input logic [1:0] m);
    return {24'h0, 2'h0, m, f, o, s};
  endfunction : cw
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task automatic wait_req(input int n);
    int i;
    int s;
    s = n_req;
    for (i = 0; i < 3000 && n_req < s + n; i++) @(posedge pclk);
    if (n_req < s + n) begin
      n_errors++;
      $display("CHECK FAILED t=%0t request missing", $time);
      finish_test();
    end
  endtask : wait_req
  task automatic setup(input int pv, input int wv);
    apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_TIMER));
    apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_PPG));
    apb(1, A_PERIOD, pv);
    apb(1, A_WIDTH, wv);
    apb(1, A_STAT, 32'h3);
    u_load.stamps.delete();
    q0 = n_req;
  endtask : setup
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    trig = 1'b0;
    n_errors = 0;
    n_checks = 0;
    n_req = 0;
    void'($urandom(15));
    idle(5);
    presetn <= 1'b1;
    idle(1);
    chk(pin, 1'b1, "reset pin");
    chk(irq, 1'b0, "reset irq");
    apb(0, A_CTRL, 0);
    chk(r, 32'h0, "reset ctrl");
    apb(0, A_STAT, 0);
    chk(r, 32'h0, "reset status");
    apb(0, A_MASK, 0);
    chk(r, 32'h0, "reset mask");
    apb(0, A_STATE, 0);
    chk(r, 32'h4, "reset state");
    apb(0, 8'h1C, 0);
    chk(r, 32'h0, "unmapped data");
    chk({31'h0, e}, 32'h1, "unmapped error");
    $display("test reset done");
    // Continuous runs with random compares
    repeat (3) begin
      w = 1 + $urandom % 6;
      p = w + 1 + $urandom % 8;
      sl = $urandom % 3;
      setup(p, w);
      apb(1, A_CTRL, cw(ST_CMD, 0, 0, MODE_PPG) | (sl << F_CLKSEL));
      wait_req(6);
      apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_PPG));
      idle(2);
      q0 = n_req - q0;
      for (int k = 1; k < 5; k++)
        chk_n(u_load.stamps[k] - u_load.stamps[k-1],
              ((k % 2) ? p - w : w + 1) << sl, "gap");
      chk_n(u_load.stamps.size(), q0, "req count");
      r = {31'h0, pin};
      idle(30);
      chk({31'h0, pin}, r, "stop hold");
      chk_n(u_load.stamps.size(), q0, "no edges");
    end
    apb(0, A_STAT, 0);
    chk(r, 32'h3, "status");
    chk(irq, 1'b0, "masked");
    apb(1, A_MASK, 32'h1);
    idle(2);
    chk(irq, 1'b1, "irq set");
    apb(1, A_STAT, 32'h1);
    idle(2);
    chk(irq, 1'b0, "irq clr");
    apb(1, A_MASK, 32'h3);
    idle(2);
    chk(irq, 1'b1, "irq period");
    apb(1, A_STAT, 32'h3);
    idle(2);
    chk(irq, 1'b0, "irq none");
    $display("test continuous done");
    // One-shot
    setup(10, 3);
    apb(1, A_CTRL, cw(ST_CMD, 1, 0, MODE_PPG));
    wait_req(2);
    idle(20);
    apb(0, A_CTRL, 0);
    chk(r, cw(ST_STOP, 1, 0, MODE_PPG), "auto stop");
    apb(0, A_STATE, 0);
    chk(r & 32'h3, 32'h0, "idle");
    apb(0, A_COUNT, 0);
    chk(r, 32'h0000_000A, "halt count");
    chk_n(u_load.stamps.size(), 2, "one period");
    chk_n(u_load.stamps[1] - u_load.stamps[0], 7, "shot gap");
    chk(pin, 1'b1, "shot level");
    $display("test oneshot done");
    // Flip-flop control
    setup(60, 2);
    apb(1, A_CTRL, cw(ST_STOP, 0, 1, MODE_PPG));
    idle(3);
    chk(pin, 1'b0, "ff low");
    apb(1, A_CTRL, cw(ST_CMD, 0, 1, MODE_PPG));
    wait_req(1);
    apb(1, A_CTRL, cw(ST_STOP, 0, 1, MODE_PPG));
    idle(3);
    chk(pin, 1'b1, "inverted hold");
    apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_PPG));
    idle(3);
    chk(pin, 1'b0, "inverse load");
    apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_TIMER));
    apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_PPG));
    idle(3);
    chk(pin, 1'b1, "reinit");
    $display("test flipflop done");
    // Trigger start, both edges; short pulses must not start
    for (int k = 0; k < 2; k++) begin
      trig <= k[0];
      setup(200, 100);
      idle(20);
      apb(1, A_CTRL, cw(k ? ST_FALL : ST_RISE, 0, 0, MODE_PPG));
      idle(5);
      trig <= ~k[0];
      idle(4);
      trig <= k[0];
      idle(30);
      apb(0, A_STATE, 0);
      chk(r & 32'h3, 32'h1, "short rejected");
      trig <= ~k[0];
      idle(30);
      apb(0, A_STATE, 0);
      chk(r & 32'h3, 32'h2, "edge start");
      apb(1, A_CTRL, cw(ST_STOP, 0, 0, MODE_PPG));
    end
    $display("test trigger done");
    finish_test();
  end
endmodule : programmable_pulse_output_tb_top
